// file: src/fdcsf_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fdcsf_defs.svh"

module fdcsf_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Command engine events, same clock
  input wire logic i_result_clear,
  input wire logic i_cmd_read,
  input wire logic i_cmd_scan,
  input wire logic i_ev_no_data_mark,
  input wire logic i_ev_deleted_mark,
  input wire logic i_ev_data_crc_err,
  input wire logic i_ev_scan_equal,
  input wire logic i_ev_scan_unsat,
  input wire logic i_id_check,
  input wire logic [7:0] i_medium_cyl,
  input wire logic [7:0] i_sector_id_cyl,
  // Drive selects as driven by the controller, same clock
  input wire logic i_head_side,
  input wire logic [1:0] i_unit_sel,
  // Drive pins, asynchronous
  input wire logic i_drive_fault,
  input wire logic i_write_protect,
  input wire logic i_drive_ready,
  input wire logic i_track_zero,
  input wire logic i_two_sided,
  // Host I/O decode pins, asynchronous
  input wire logic i_drive_group_sel,
  input wire logic i_io_aen,
  input wire logic [9:0] i_io_addr,
  output logic o_io_sel,
  output logic [2:0] o_io_port,
  // Interrupt
  output logic o_irq
);

  localparam int PIN_W = 17;

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("fdcsf_top: ADDR_W must lie between 8 and 32");
    end
  end

  // Widened first so the upper-bits test also holds at ADDR_W of 8
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [31:0] wide;
    logic [7:0] lo;
    wide = 32'(a);
    lo = a[7:0];
    is_mapped = (wide[31:8] == 24'h0) &&
      (lo == `FDCSF_OFF_RES_B || lo == `FDCSF_OFF_RES_C ||
       lo == `FDCSF_OFF_DRV || lo == `FDCSF_OFF_IRQ_ST ||
       lo == `FDCSF_OFF_IRQ_MSK);
  endfunction

  function automatic logic io_hit(input logic [9:0] a, input logic grp);
    if (grp) begin
      io_hit = (a >= `FDCSF_PRI_LO && a <= `FDCSF_PRI_HI) ||
        a == `FDCSF_PRI_ALT;
    end else begin
      io_hit = (a >= `FDCSF_SEC_LO && a <= `FDCSF_SEC_HI) ||
        a == `FDCSF_SEC_ALT;
    end
  endfunction

  // Pin synchroniser
  fdcsf_sync_if #(.W(PIN_W)) pins ();

  assign pins.raw = {i_io_aen, i_io_addr, i_drive_group_sel, i_drive_fault,
    i_write_protect, i_drive_ready, i_track_zero, i_two_sided};

  fdcsf_sync #(.W(PIN_W)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bus(pins.syncer)
  );

  logic s_aen;
  logic [9:0] s_addr;
  logic s_grp;
  logic [4:0] s_drv;
  assign s_aen = pins.sync[16];
  assign s_addr = pins.sync[15:6];
  assign s_grp = pins.sync[5];
  assign s_drv = pins.sync[4:0];

  // Status registers
  logic res_b_miss_q;
  logic [6:0] res_c_q;
  logic [7:0] drv_q;
  logic rdy_prev_q;
  logic [`FDCSF_IRQ_W-1:0] irq_st_q;
  logic [`FDCSF_IRQ_W-1:0] irq_msk_q;

  logic miss_ev;
  logic del_ev;
  logic cyl_ev;
  logic bad_ev;
  logic seq_ev;
  logic suns_ev;
  logic rdy_ev;
  assign miss_ev = i_ev_no_data_mark;
  assign del_ev = i_ev_deleted_mark && (i_cmd_read || i_cmd_scan);
  assign cyl_ev = i_id_check && (i_medium_cyl != i_sector_id_cyl);
  assign bad_ev = cyl_ev && (i_medium_cyl == `FDCSF_BAD_CYL);
  assign seq_ev = i_cmd_scan && i_ev_scan_equal;
  assign suns_ev = i_cmd_scan && i_ev_scan_unsat;
  assign rdy_ev = s_drv[2] != rdy_prev_q;

  // Clear starts a new command; an event in the same cycle still lands
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      res_b_miss_q <= 1'b0;
      res_c_q <= 7'(`FDCSF_RST_RES);
    end else begin
      if (i_result_clear) begin
        res_b_miss_q <= 1'b0;
        res_c_q <= 7'h00;
      end
      if (miss_ev) begin
        res_b_miss_q <= 1'b1;
        res_c_q[`FDCSF_C_MD] <= 1'b1;
      end
      if (del_ev) begin
        res_c_q[`FDCSF_C_DELETED] <= 1'b1;
      end
      if (i_ev_data_crc_err) begin
        res_c_q[`FDCSF_C_CRC] <= 1'b1;
      end
      if (cyl_ev) begin
        res_c_q[`FDCSF_C_CYL] <= 1'b1;
      end
      if (seq_ev) begin
        res_c_q[`FDCSF_C_SEQ] <= 1'b1;
      end
      if (suns_ev) begin
        res_c_q[`FDCSF_C_SUNS] <= 1'b1;
      end
      if (bad_ev) begin
        res_c_q[`FDCSF_C_BAD] <= 1'b1;
      end
    end
  end

  // Live drive view; selects are the levels this controller drives
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      drv_q <= `FDCSF_RST_RES;
      rdy_prev_q <= 1'b0;
    end else begin
      drv_q <= {s_drv, i_head_side, i_unit_sel};
      rdy_prev_q <= s_drv[2];
    end
  end

  // Legacy port decode, registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_io_sel <= 1'b0;
      o_io_port <= 3'h0;
    end else begin
      o_io_sel <= !s_aen && io_hit(s_addr, s_grp);
      o_io_port <= s_addr[2:0];
    end
  end

  // AXI write channel
  fdcsf_pkg::fdcsf_wr_state_t wst_q;
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign aw_fire = i_awvalid && o_awready;
  assign w_fire = i_wvalid && o_wready;
  assign wr_go = (wst_q == fdcsf_pkg::FDCSF_WS_IDLE) &&
    (aw_got_q || aw_fire) && (w_got_q || w_fire);
  assign wr_addr = aw_fire ? i_awaddr : awaddr_q;
  assign wr_data = w_fire ? i_wdata : wdata_q;
  assign wr_strb = w_fire ? i_wstrb : wstrb_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wst_q <= fdcsf_pkg::FDCSF_WS_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `FDCSF_RESP_OKAY;
    end else begin
      unique case (wst_q)
        fdcsf_pkg::FDCSF_WS_IDLE: begin
          if (aw_fire) begin
            aw_got_q <= 1'b1;
            awaddr_q <= i_awaddr;
            o_awready <= 1'b0;
          end
          if (w_fire) begin
            w_got_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
            o_wready <= 1'b0;
          end
          if (wr_go) begin
            wst_q <= fdcsf_pkg::FDCSF_WS_RESP;
            o_bvalid <= 1'b1;
            o_bresp <= is_mapped(wr_addr) ? `FDCSF_RESP_OKAY :
              `FDCSF_RESP_SLVERR;
          end
        end
        fdcsf_pkg::FDCSF_WS_RESP: begin
          if (i_bready) begin
            wst_q <= fdcsf_pkg::FDCSF_WS_IDLE;
            o_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
          end
        end
      endcase
    end
  end

  // Interrupts: sticky, write one to clear, a new event beats the clear
  logic [`FDCSF_IRQ_W-1:0] irq_ev;
  logic [`FDCSF_IRQ_W-1:0] irq_clr;
  assign irq_ev = {rdy_ev, suns_ev, seq_ev, cyl_ev, i_ev_data_crc_err,
    miss_ev};
  assign irq_clr = (wr_go && wr_strb[0] &&
    wr_addr[7:0] == `FDCSF_OFF_IRQ_ST && is_mapped(wr_addr)) ?
    wr_data[`FDCSF_IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      irq_st_q <= `FDCSF_RST_IRQ;
      irq_msk_q <= `FDCSF_RST_IRQ;
      o_irq <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      if (wr_go && wr_strb[0] && is_mapped(wr_addr) &&
          wr_addr[7:0] == `FDCSF_OFF_IRQ_MSK) begin
        irq_msk_q <= wr_data[`FDCSF_IRQ_W-1:0];
      end
      o_irq <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_msk_q);
    end
  end

  // AXI read channel; result and drive status registers have no write path at all
  fdcsf_pkg::fdcsf_rd_state_t rst_q;
  logic ar_fire;
  logic [31:0] rd_word;
  assign ar_fire = i_arvalid && o_arready;

  always_comb begin
    rd_word = 32'h0;
    unique case (i_araddr[7:0])
      `FDCSF_OFF_RES_B: rd_word[`FDCSF_B_MISS_MARK] = res_b_miss_q;
      `FDCSF_OFF_RES_C: rd_word[7:0] = {1'b0, res_c_q};
      `FDCSF_OFF_DRV: rd_word[7:0] = drv_q;
      `FDCSF_OFF_IRQ_ST: rd_word[`FDCSF_IRQ_W-1:0] = irq_st_q;
      `FDCSF_OFF_IRQ_MSK: rd_word[`FDCSF_IRQ_W-1:0] = irq_msk_q;
      default: rd_word = 32'h0;
    endcase
    if (!is_mapped(i_araddr)) begin
      rd_word = 32'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rst_q <= fdcsf_pkg::FDCSF_RS_IDLE;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `FDCSF_RESP_OKAY;
    end else begin
      unique case (rst_q)
        fdcsf_pkg::FDCSF_RS_IDLE: begin
          if (ar_fire) begin
            rst_q <= fdcsf_pkg::FDCSF_RS_DATA;
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= is_mapped(i_araddr) ? `FDCSF_RESP_OKAY :
              `FDCSF_RESP_SLVERR;
          end
        end
        fdcsf_pkg::FDCSF_RS_DATA: begin
          if (i_rready) begin
            rst_q <= fdcsf_pkg::FDCSF_RS_IDLE;
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
          end
        end
      endcase
    end
  end

  // Checks; pin relations wait until the sync pipe has refilled
  logic [1:0] up_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence wr_both_taken;
    wr_go;
  endsequence

  sequence rd_taken;
    ar_fire && (i_araddr[7:0] == `FDCSF_OFF_RES_C);
  endsequence

  mark_pair_a: assert property (
    res_b_miss_q == res_c_q[`FDCSF_C_MD])
    else $error("missing mark flags disagree");

  msb_zero_a: assert property (
    rd_taken |=> o_rvalid && !o_rdata[7])
    else $error("status c top bit not zero");

  deleted_set_a: assert property (
    i_ev_deleted_mark && i_cmd_read |=> res_c_q[`FDCSF_C_DELETED])
    else $error("deleted mark flag not set");

  crc_set_a: assert property (
    i_ev_data_crc_err |=> res_c_q[`FDCSF_C_CRC] && irq_st_q[`FDCSF_I_CRC])
    else $error("data crc flag not set");

  cyl_diff_a: assert property (
    i_id_check && i_medium_cyl != i_sector_id_cyl |=>
      res_c_q[`FDCSF_C_CYL])
    else $error("cylinder mismatch not flagged");

  scan_hit_a: assert property (
    i_cmd_scan && i_ev_scan_equal |=> res_c_q[`FDCSF_C_SEQ])
    else $error("scan equal not flagged");

  scan_miss_a: assert property (
    i_cmd_scan && i_ev_scan_unsat |=> res_c_q[`FDCSF_C_SUNS])
    else $error("scan unsatisfied not flagged");

  scan_only_a: assert property (
    !i_cmd_scan && !i_result_clear && !res_c_q[`FDCSF_C_SUNS] |=>
      !res_c_q[`FDCSF_C_SUNS])
    else $error("scan flag set outside scan");

  bad_track_a: assert property (
    i_id_check && i_medium_cyl == `FDCSF_BAD_CYL &&
      i_sector_id_cyl != `FDCSF_BAD_CYL |=> res_c_q[`FDCSF_C_BAD])
    else $error("bad cylinder not flagged");

  no_mark_a: assert property (
    i_ev_no_data_mark |=> res_c_q[`FDCSF_C_MD] && res_b_miss_q)
    else $error("missing data mark not flagged");

  pin_view_a: assert property (
    up_q == 2'h3 |-> drv_q[7:3] == $past({i_drive_fault, i_write_protect,
      i_drive_ready, i_track_zero, i_two_sided}, `FDCSF_PIN_LAT))
    else $error("drive pin view lags or wrong");

  sel_view_a: assert property (
    ##1 drv_q[2:0] == $past({i_head_side, i_unit_sel}))
    else $error("select view wrong");

  io_primary_a: assert property (
    up_q == 2'h3 && $past(i_drive_group_sel, `FDCSF_PIN_LAT) &&
      !$past(i_io_aen, `FDCSF_PIN_LAT) &&
      $past(i_io_addr, `FDCSF_PIN_LAT) == `FDCSF_PRI_ALT |-> o_io_sel)
    else $error("primary address not decoded");

  ro_write_a: assert property (
    wr_both_taken ##0 (!i_result_clear && !miss_ev && !del_ev &&
      !i_ev_data_crc_err && !cyl_ev && !seq_ev && !suns_ev) |=>
      $stable(res_c_q) && $stable(res_b_miss_q))
    else $error("host write changed a status flag");

  wr_resp_a: assert property (
    wr_both_taken |=> o_bvalid [*1] ##0 !o_awready && !o_wready)
    else $error("write response missing");

endmodule

`default_nettype wire

// file: src/fdcsf_defs.svh
`ifndef FDCSF_DEFS_SVH
`define FDCSF_DEFS_SVH

// Register byte offsets
`define FDCSF_OFF_RES_B 8'h00
`define FDCSF_OFF_RES_C 8'h04
`define FDCSF_OFF_DRV 8'h08
`define FDCSF_OFF_IRQ_ST 8'h0C
`define FDCSF_OFF_IRQ_MSK 8'h10

// result_status_b fields
`define FDCSF_B_MISS_MARK 0

// result_status_c fields
`define FDCSF_C_UNUSED 7
`define FDCSF_C_DELETED 6
`define FDCSF_C_CRC 5
`define FDCSF_C_CYL 4
`define FDCSF_C_SEQ 3
`define FDCSF_C_SUNS 2
`define FDCSF_C_BAD 1
`define FDCSF_C_MD 0

// drive_signal_status fields
`define FDCSF_D_FT 7
`define FDCSF_D_WP 6
`define FDCSF_D_RDY 5
`define FDCSF_D_T0 4
`define FDCSF_D_TS 3
`define FDCSF_D_HD 2
`define FDCSF_D_US1 1
`define FDCSF_D_US0 0

// Interrupt status and mask fields
`define FDCSF_IRQ_W 6
`define FDCSF_I_MISS 0
`define FDCSF_I_CRC 1
`define FDCSF_I_CYL 2
`define FDCSF_I_SEQ 3
`define FDCSF_I_SUNS 4
`define FDCSF_I_RDY 5

// Reset values
`define FDCSF_RST_RES 8'h00
`define FDCSF_RST_IRQ 6'h00

// Values
`define FDCSF_BAD_CYL 8'hFF
`define FDCSF_PRI_LO 10'h3F1
`define FDCSF_PRI_HI 10'h3F7
`define FDCSF_PRI_ALT 10'h1F7
`define FDCSF_SEC_LO 10'h371
`define FDCSF_SEC_HI 10'h377
`define FDCSF_SEC_ALT 10'h177
`define FDCSF_RESP_OKAY 2'h0
`define FDCSF_RESP_SLVERR 2'h2

// Pin to status latency: two sync flops plus the status flop
`define FDCSF_PIN_LAT 3

`endif

// file: src/fdcsf_pkg.sv
package fdcsf_pkg;

  typedef enum logic [1:0] {
    FDCSF_WS_IDLE = 2'h1,
    FDCSF_WS_RESP = 2'h2
  } fdcsf_wr_state_t;

  typedef enum logic [1:0] {
    FDCSF_RS_IDLE = 2'h1,
    FDCSF_RS_DATA = 2'h2
  } fdcsf_rd_state_t;

endpackage

// file: src/fdcsf_sync_if.sv
`timescale 1ns/1ns
`default_nettype none

interface fdcsf_sync_if #(
  parameter int W = 17
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport owner (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface

`default_nettype wire

// file: src/fdcsf_sync.sv
`timescale 1ns/1ns
`default_nettype none

module fdcsf_sync #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Pins in, synchronised levels out
  fdcsf_sync_if.syncer bus
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  initial begin
    if (W < 1) begin
      $error("fdcsf_sync: width must be at least one");
    end
  end

  // First stage feeds the second stage only
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= bus.raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign bus.sync = sync_q;

endmodule

`default_nettype wire

// file: bench/fdcsf_drive_model.sv
`timescale 1ns/1ns
`default_nettype none

// Drive side: static levels, held until the bench changes them
module fdcsf_drive_model (
  // Levels requested by the bench, {fault,wp,ready,track0,two_sided}
  input wire logic [4:0] i_lvl,
  // Drive pins
  output logic o_fault,
  output logic o_wp,
  output logic o_ready,
  output logic o_track0,
  output logic o_two_sided
);
  assign {o_fault, o_wp, o_ready, o_track0, o_two_sided} = i_lvl;
endmodule

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "fdcsf_defs.svh"

module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, mcyl = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic clr = 1'b0, cmd_rd = 1'b1, cmd_sc = 1'b1, idc = 1'b0;
  logic [7:0] sid = 8'h03;
  logic hd = 1'b0, gsel = 1'b1, aen = 1'b0;
  logic [4:0] ev = 5'h00, lvl = 5'h00;
  logic [1:0] us = 2'h0, r, bresp, rresp;
  logic [9:0] ioa = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, io_sel, irq;
  logic fault, wp, rdy, t0, ts;
  logic [31:0] rdata;
  logic [2:0] io_port;
  int errors = 0, compares = 0;
  logic [4:0] evs [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00,
    5'h00, 5'h00};
  logic [7:0] cy [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05,
    8'hFF, 8'h03};
  logic [7:0] exc [8] = '{8'h01, 8'h40, 8'h20, 8'h08, 8'h04, 8'h10,
    8'h12, 8'h00};
  logic [9:0] ad [8] = '{10'h3F1, 10'h3F7, 10'h1F7, 10'h3F0, 10'h371,
    10'h371, 10'h3F8, 10'h3F3};
  logic [7:0] gs = 8'hDF, ae = 8'h80, es = 8'h27;

  always #2 clk = ~clk;

  fdcsf_drive_model drv (.i_lvl(lvl), .o_fault(fault), .o_wp(wp),
    .o_ready(rdy), .o_track0(t0), .o_two_sided(ts));

  fdcsf_top dut (.i_clk(clk), .i_rst_b(rst_b),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_awprot(3'h0), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_result_clear(clr), .i_cmd_read(cmd_rd),
    .i_cmd_scan(cmd_sc), .i_ev_no_data_mark(ev[0]),
    .i_ev_deleted_mark(ev[1]), .i_ev_data_crc_err(ev[2]),
    .i_ev_scan_equal(ev[3]), .i_ev_scan_unsat(ev[4]), .i_id_check(idc),
    .i_medium_cyl(mcyl), .i_sector_id_cyl(sid), .i_head_side(hd),
    .i_unit_sel(us), .i_drive_fault(fault), .i_write_protect(wp),
    .i_drive_ready(rdy), .i_track_zero(t0), .i_two_sided(ts),
    .i_drive_group_sel(gsel), .i_io_aen(aen), .i_io_addr(ioa),
    .o_io_sel(io_sel), .o_io_port(io_port), .o_irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("wrong value at %0t ns: handshake timeout", $time);
    close_out();
  endtask

  // Ready lines sampled at the falling edge: they are what the next
  // rising edge sees, so the bench never races the flops
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input string m);
    axr(a, d, r);
    chk(d, e, m);
    chk({30'h0, r}, {30'h0, `FDCSF_RESP_OKAY}, "read response");
  endtask

  task automatic pulse(input logic c, input logic [4:0] e, input logic i,
    input logic [7:0] m);
    @(posedge clk);
    clr <= c;
    ev <= e;
    idc <= i;
    mcyl <= m;
    @(posedge clk);
    clr <= 1'b0;
    ev <= 5'h00;
    idc <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`FDCSF_OFF_RES_B, 32'h0, "status b at reset");
    rd(`FDCSF_OFF_RES_C, 32'h0, "status c at reset");
    rd(`FDCSF_OFF_DRV, 32'h0, "drive status at reset");
    rd(`FDCSF_OFF_IRQ_MSK, 32'h0, "mask at reset");
    axr(8'h14, d, r);
    chk({30'h0, r}, {30'h0, `FDCSF_RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0, "unmapped read data");
    axw(8'h14, 32'h1, r);
    chk({30'h0, r}, {30'h0, `FDCSF_RESP_SLVERR}, "unmapped write");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pulse(1'b1, 5'h00, 1'b0, 8'h00);
      pulse(1'b0, evs[i], i > 4, cy[i]);
      rd(`FDCSF_OFF_RES_C, {24'h0, exc[i]}, "status c flag");
      rd(`FDCSF_OFF_RES_B, {31'h0, i == 0}, "missing mark");
    end
    // No command running, and an equal FF cylinder is not a bad track
    cmd_rd <= 1'b0;
    cmd_sc <= 1'b0;
    sid <= 8'hFF;
    pulse(1'b1, 5'h00, 1'b0, 8'h00);
    pulse(1'b0, 5'h1A, 1'b1, 8'hFF);
    rd(`FDCSF_OFF_RES_C, 32'h0, "flags outside command");
    $display("test result flags done");
    pulse(1'b0, 5'h04, 1'b0, 8'h00);
    axw(`FDCSF_OFF_RES_C, 32'hFFFFFFFF, r);
    axw(`FDCSF_OFF_RES_B, 32'hFFFFFFFF, r);
    axw(`FDCSF_OFF_DRV, 32'hFFFFFFFF, r);
    rd(`FDCSF_OFF_RES_C, 32'h20, "status c after write");
    rd(`FDCSF_OFF_RES_B, 32'h0, "status b after write");
    rd(`FDCSF_OFF_DRV, 32'h0, "drive status after write");
    $display("test read only done");
    axw(`FDCSF_OFF_IRQ_ST, 32'h3F, r);
    axw(`FDCSF_OFF_IRQ_MSK, 32'h1, r);
    rd(`FDCSF_OFF_IRQ_MSK, 32'h1, "mask readback");
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    pulse(1'b0, 5'h01, 1'b0, 8'h00);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1, "irq on unmasked event");
    rd(`FDCSF_OFF_IRQ_ST, 32'h1, "irq status set");
    axw(`FDCSF_OFF_IRQ_ST, 32'h1, r);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq after w1c");
    pulse(1'b0, 5'h04, 1'b0, 8'h00);
    rd(`FDCSF_OFF_IRQ_ST, 32'h2, "masked status set");
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq stays low when masked");
    $display("test interrupt done");
    // One level at a time, so a swapped bit shows up
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      lvl <= (i < 5) ? 5'(1 << i) : 5'h00;
      {hd, us} <= (i > 4) ? 3'(1 << (i - 5)) : 3'h0;
      repeat (6) @(posedge clk);
      rd(`FDCSF_OFF_DRV, 32'(1 << (i < 5 ? i + 3 : i - 5)), "drive pins");
    end
    $display("test drive status done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ioa <= ad[i];
      gsel <= gs[i];
      aen <= ae[i];
      repeat (6) @(negedge clk);
      chk({28'h0, io_sel, io_port}, {28'h0, es[i], ad[i][2:0]}, "decode");
    end
    $display("test decode done");
    close_out();
  end
endmodule

`default_nettype wire
